// ### rtl/eos_params.svh
// Constants of the residual overcurrent stage block.
// Assumes a 25 MHz clock and a byte-addressed Avalon-MM slave.
// ==================================================================
// Summary of operation
// - Pick-up when the selected residual magnitude exceeds the level.
// - Release only below 97 percent of the pick-up level.
// - One pick-up level serves every compared magnitude of a stage.
// - Level set in 0.0001 of nominal units, default 1.20 nominal.
// - Settings change while the stage keeps evaluating.
// - Blocking input sampled once at each tick, before the decision.
// - Pick-up without blocking asserts start and runs the delay.
// - Pick-up with blocking asserts blocked, no timing, no trip.
// - Blocking after start drops start and reloads as on release.
// - Optional second-harmonic inrush block, disabled by default.
// - Inrush block when harmonic ratio exceeds a 0.01 percent limit.
// - Fixed-time or inverse minimum-time delay, selectable.
// - Four independent stages, each with its own events.
// - On, off or both transitions reported, each with a time stamp.
// - Clearable counts of start, trip and blocked per stage.
// - Twelve newest fault records per stage, oldest overwritten.
// - Record holds time, event, fault type, currents, remain, group.
// - Remaining time to trip counts down in 5 ms steps.
// - State is normal, start, trip or blocked; ratio is reported.
// - Angle against voltage reference, else against current.
// - Fault type is phase, ground and direction, or none.
// - Source is coarse, sensitive or computed; kind selectable for coarse and sensitive.
// - Forcing overrides the stage outputs and events, not the status register, normal by default.
`ifndef EOS_PARAMS_SVH
`define EOS_PARAMS_SVH
// ==================================================================
// Timing
`define EOS_TICK_MS 5
`define EOS_CLK_KHZ 25000
`define EOS_PRE_TRIG_MS 20
`define EOS_PRE_FAULT_MS 200
// ==================================================================
// Widths and scaling
`define EOS_MAGW 20
`define EOS_TMRW 19
`define EOS_RATW 17
`define EOS_CNTW 16
`define EOS_REC_DEPTH 12
`define EOS_PCT_FULL 34'h0000000064
`define EOS_HYST_PCT 34'h0000000061
`define EOS_HARM_SCALE 34'h0000002710
// ==================================================================
// Reset values
`define EOS_LVL_RST 20'h02EE0
`define EOS_DLY_RST 19'h00014
`define EOS_HARM_RST 13'h0001
// ==================================================================
// Global register offsets
`define EOS_OFF_CTRL 8'h00
`define EOS_OFF_HARM 8'h04
`define EOS_OFF_CLR 8'h08
`define EOS_OFF_RSEL 8'h0C
`define EOS_OFF_RTIME 8'h10
`define EOS_OFF_RA 8'h14
`define EOS_OFF_RB 8'h18
`define EOS_OFF_RC 8'h1C
`define EOS_OFF_RD 8'h20
`define EOS_OFF_ANGLE 8'h24
// Stage registers: base 0x80, stride 0x20
`define EOS_STG_BIT 7
`define EOS_SR_LEVEL 3'h0
`define EOS_SR_DELAY 3'h1
`define EOS_SR_CFG 3'h2
`define EOS_SR_STAT 3'h3
`define EOS_SR_REMAIN 3'h4
`define EOS_SR_CNT_ST 3'h5
`define EOS_SR_CNT_BK 3'h6
`define EOS_SR_FAULT 3'h7
// ==================================================================
// Fields
`define EOS_CTRL_SRC 1:0
`define EOS_CTRL_KIND 3:2
`define EOS_CTRL_FORCE 4
`define EOS_CFG_INVERSE_MIN_TIME_DELAY 0
`define EOS_CFG_INRUSH 1
`define EOS_CFG_FSTATE 3:2
`define EOS_CFG_EVON 4
`define EOS_CFG_EVOFF 5
`define EOS_RSEL_SLOT 3:0
`define EOS_RSEL_STAGE 5:4
`endif

// ### rtl/eos_pkg.sv
// Types of the residual overcurrent stage block.
// Assumes eos_params.svh on the include path.
`include "eos_params.svh"
package eos_pkg;
  typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED}
    eos_state_t;
  typedef enum logic [1:0] {SRC_COARSE, SRC_SENS, SRC_CALC} eos_src_t;
  typedef enum logic [1:0] {KIND_RMS, KIND_TRMS, KIND_PP} eos_kind_t;
  typedef enum logic [1:0] {EV_START, EV_TRIP, EV_BLOCK} eos_evt_t;
  typedef logic [2:0] eos_flags_t;
  typedef logic [`EOS_MAGW-1:0] eos_mag_t;
  typedef struct packed {
    logic [1:0] phase;
    logic ground;
    logic fwd;
  } eos_fault_t;
  typedef struct packed {
    logic [31:0] stamp;
    eos_evt_t evt;
    eos_fault_t fault;
    eos_mag_t pre_trig;
    eos_mag_t cur;
    eos_mag_t pre_fault;
    logic [`EOS_TMRW-1:0] remain;
    logic [2:0] group;
  } eos_rec_t;
endpackage : eos_pkg

// ### rtl/eos_stage.sv
// Residual overcurrent protection, several stages, one evaluator.
// Assumes measurement inputs synchronous to clock, Avalon-MM master.
`timescale 1ns/10ps
`include "eos_params.svh"
module eos_stage #(
  parameter int NSTAGE = 4,
  parameter int TICK_CYC = `EOS_TICK_MS * `EOS_CLK_KHZ
) (
  input logic clock,
  input logic nrst,
  input logic [7:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input eos_pkg::eos_mag_t coarse_rms,
  input eos_pkg::eos_mag_t coarse_trms,
  input eos_pkg::eos_mag_t coarse_pp,
  input eos_pkg::eos_mag_t sens_rms,
  input eos_pkg::eos_mag_t sens_trms,
  input eos_pkg::eos_mag_t sens_pp,
  input eos_pkg::eos_mag_t calc_rms,
  input eos_pkg::eos_mag_t harm2_mag,
  input eos_pkg::eos_mag_t fund_mag,
  input logic [NSTAGE-1:0] ext_block,
  input logic [15:0] resid_angle,
  input logic [15:0] vpos_angle,
  input logic [15:0] ipos_angle,
  input logic volt_avail,
  input logic [1:0] fault_phase,
  input logic fault_fwd,
  input logic [2:0] setting_group,
  input logic [31:0] timestamp,
  output logic [NSTAGE-1:0] stage_start,
  output logic [NSTAGE-1:0] stage_trip,
  output logic [NSTAGE-1:0] stage_blocked,
  output logic evt_valid,
  output logic [1:0] evt_stage,
  output eos_pkg::eos_flags_t evt_on,
  output eos_pkg::eos_flags_t evt_off,
  output logic [31:0] evt_time
);
  import eos_pkg::*;

  localparam int TRIG_IX = `EOS_PRE_TRIG_MS / `EOS_TICK_MS - 1;
  localparam int HIST_LEN = `EOS_PRE_FAULT_MS / `EOS_TICK_MS;
  localparam int RDEP = `EOS_REC_DEPTH;

  if (NSTAGE < 1 || NSTAGE > 4 || TICK_CYC <= NSTAGE + 1) begin : g_chk
    $error("eos_stage: unsupported NSTAGE or TICK_CYC");
  end

  // ================================================================
  // Configuration and status storage
  logic [1:0] src_r, kind_r;
  logic force_en_r;
  logic [12:0] harm_lim_r;
  logic [5:0] rsel_r;
  logic [NSTAGE-1:0] cnt_clr_r, inverse_min_time_delay_r, inrush_r, evon_r, evoff_r;
  eos_mag_t lvl_r [NSTAGE];
  logic [`EOS_TMRW-1:0] dly_r [NSTAGE];
  logic [1:0] fsel_r [NSTAGE];
  eos_state_t st_r [NSTAGE];
  logic [NSTAGE-1:0] pick_r;
  logic [`EOS_TMRW-1:0] tmr_r [NSTAGE];
  logic [`EOS_TMRW-1:0] remain_r [NSTAGE];
  logic [`EOS_RATW-1:0] ratio_r [NSTAGE];
  logic [`EOS_CNTW-1:0] cnt_st_r [NSTAGE];
  logic [`EOS_CNTW-1:0] cnt_tr_r [NSTAGE];
  logic [`EOS_CNTW-1:0] cnt_bk_r [NSTAGE];
  logic [3:0] wptr_r [NSTAGE];
  eos_fault_t last_fault_r [NSTAGE];
  eos_rec_t rec_mem [NSTAGE*RDEP];
  logic [16:0] angle_r;

  // ================================================================
  // Evaluation tick and stage sweep
  logic [31:0] tcnt_r;
  logic tick_r, step_v_r;
  logic [1:0] step_idx_r;
  eos_mag_t mag_l_r, mag_sel;
  eos_mag_t hist_r [HIST_LEN];
  logic [NSTAGE-1:0] blk_l_r;
  logic harm_l_r;
  logic [31:0] ts_l_r;
  eos_fault_t flt_l_r;
  logic [2:0] grp_l_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tcnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (tcnt_r == 32'(TICK_CYC - 1)) begin
      tcnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      tcnt_r <= tcnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      step_v_r <= 1'b0;
      step_idx_r <= 2'h0;
    end else if (tick_r) begin
      step_v_r <= 1'b1;
      step_idx_r <= 2'h0;
    end else if (step_v_r) begin
      step_v_r <= (step_idx_r != 2'(NSTAGE - 1));
      step_idx_r <= step_idx_r + 2'h1;
    end
  end

  always_comb begin
    mag_sel = calc_rms;
    unique case (eos_src_t'(src_r))
      SRC_COARSE: mag_sel = (kind_r == KIND_TRMS) ? coarse_trms :
                            (kind_r == KIND_PP) ? coarse_pp : coarse_rms;
      SRC_SENS: mag_sel = (kind_r == KIND_TRMS) ? sens_trms :
                          (kind_r == KIND_PP) ? sens_pp : sens_rms;
      SRC_CALC: mag_sel = calc_rms;
      default: mag_sel = calc_rms;
    endcase
  end

  // Inputs latched at tick, blocking sampled before any decision
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mag_l_r <= '0;
      blk_l_r <= '0;
      harm_l_r <= 1'b0;
      ts_l_r <= 32'h0;
      flt_l_r <= '0;
      grp_l_r <= 3'h0;
    end else if (tick_r) begin
      mag_l_r <= mag_sel;
      blk_l_r <= ext_block;
      harm_l_r <= (34'(harm2_mag) * `EOS_HARM_SCALE) >
                  (34'(harm_lim_r) * 34'(fund_mag));
      ts_l_r <= timestamp;
      flt_l_r <= '{fault_phase, fault_phase != 2'h0, fault_fwd};
      grp_l_r <= setting_group;
    end
  end

  always_ff @(posedge clock) begin
    if (tick_r) begin
      hist_r[0] <= mag_l_r;
      for (int i = 1; i < HIST_LEN; i++) begin
        hist_r[i] <= hist_r[i-1];
      end
    end
  end

  // ================================================================
  // Per-stage decision for the stage under evaluation
  eos_mag_t lvl;
  logic above, below, pk_n, blk;
  logic [33:0] quot;
  logic [`EOS_RATW-1:0] ratio_n, dec;
  eos_state_t st_c, st_n, disp_n;
  logic [`EOS_TMRW-1:0] tmr_n;
  eos_flags_t fl_n, fl_o, on_v, off_v;

  always_comb begin
    lvl = lvl_r[step_idx_r];
    above = mag_l_r > lvl;
    below = (34'(mag_l_r) * `EOS_PCT_FULL) < (34'(lvl) * `EOS_HYST_PCT);
    pk_n = pick_r[step_idx_r] ? !below : above;
    blk = blk_l_r[step_idx_r] | (inrush_r[step_idx_r] & harm_l_r);
    quot = (34'(mag_l_r) * `EOS_PCT_FULL) /
           ((lvl == '0) ? 34'h1 : 34'(lvl));
    ratio_n = (quot > 34'({`EOS_RATW{1'b1}})) ? '1 : quot[`EOS_RATW-1:0];
    dec = 17'h1;
    if (inverse_min_time_delay_r[step_idx_r] && (quot >= 34'h000000C8)) begin
      dec = 17'(quot / `EOS_PCT_FULL);
    end
    st_c = st_r[step_idx_r];
    st_n = st_c;
    tmr_n = tmr_r[step_idx_r];
    if (!pk_n) begin
      st_n = ST_NORMAL;
      tmr_n = dly_r[step_idx_r];
    end else begin
      unique case (st_c)
        ST_NORMAL: begin
          st_n = blk ? ST_BLOCKED : ST_START;
          tmr_n = dly_r[step_idx_r];
        end
        ST_START: begin
          if (blk) begin
            st_n = ST_BLOCKED;
            tmr_n = dly_r[step_idx_r];
          end else if (19'(dec) >= tmr_r[step_idx_r]) begin
            st_n = ST_TRIP;
            tmr_n = '0;
          end else begin
            tmr_n = tmr_r[step_idx_r] - 19'(dec);
          end
        end
        ST_TRIP, ST_BLOCKED: st_n = st_c;
      endcase
    end
    disp_n = force_en_r ? eos_state_t'(fsel_r[step_idx_r]) : st_n;
    fl_n = {disp_n == ST_BLOCKED, disp_n == ST_TRIP,
            disp_n == ST_START || disp_n == ST_TRIP};
    fl_o = {stage_blocked[step_idx_r], stage_trip[step_idx_r],
            stage_start[step_idx_r]};
    on_v = fl_n & ~fl_o;
    off_v = ~fl_n & fl_o;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pick_r <= '0;
      stage_start <= '0;
      stage_trip <= '0;
      stage_blocked <= '0;
      for (int i = 0; i < NSTAGE; i++) begin
        st_r[i] <= ST_NORMAL;
        tmr_r[i] <= '0;
        remain_r[i] <= '0;
        ratio_r[i] <= '0;
      end
    end else if (step_v_r) begin
      pick_r[step_idx_r] <= pk_n;
      st_r[step_idx_r] <= st_n;
      tmr_r[step_idx_r] <= tmr_n;
      remain_r[step_idx_r] <= (st_n == ST_START) ? tmr_n : '0;
      ratio_r[step_idx_r] <= ratio_n;
      stage_start[step_idx_r] <= fl_n[0];
      stage_trip[step_idx_r] <= fl_n[1];
      stage_blocked[step_idx_r] <= fl_n[2];
    end
  end

  // ================================================================
  // Events and counters
  always_ff @(posedge clock) begin
    if (!nrst) begin
      evt_valid <= 1'b0;
      evt_stage <= 2'h0;
      evt_on <= '0;
      evt_off <= '0;
      evt_time <= 32'h0;
    end else begin
      evt_valid <= step_v_r && ((evon_r[step_idx_r] && on_v != '0) ||
                   (evoff_r[step_idx_r] && off_v != '0));
      evt_stage <= step_idx_r;
      evt_on <= evon_r[step_idx_r] ? on_v : '0;
      evt_off <= evoff_r[step_idx_r] ? off_v : '0;
      evt_time <= ts_l_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < NSTAGE; i++) begin
        cnt_st_r[i] <= '0;
        cnt_tr_r[i] <= '0;
        cnt_bk_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NSTAGE; i++) begin
        if (step_v_r && step_idx_r == 2'(i) && on_v[0]) begin
          cnt_st_r[i] <= cnt_clr_r[i] ? 16'h1 : cnt_st_r[i] + 16'h1;
        end else if (cnt_clr_r[i]) begin
          cnt_st_r[i] <= '0;
        end
        if (step_v_r && step_idx_r == 2'(i) && on_v[1]) begin
          cnt_tr_r[i] <= cnt_clr_r[i] ? 16'h1 : cnt_tr_r[i] + 16'h1;
        end else if (cnt_clr_r[i]) begin
          cnt_tr_r[i] <= '0;
        end
        if (step_v_r && step_idx_r == 2'(i) && on_v[2]) begin
          cnt_bk_r[i] <= cnt_clr_r[i] ? 16'h1 : cnt_bk_r[i] + 16'h1;
        end else if (cnt_clr_r[i]) begin
          cnt_bk_r[i] <= '0;
        end
      end
    end
  end

  // ================================================================
  // Fault records
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < NSTAGE; i++) begin
        wptr_r[i] <= 4'h0;
        last_fault_r[i] <= '0;
      end
    end else if (step_v_r && on_v != '0) begin
      wptr_r[step_idx_r] <= (wptr_r[step_idx_r] == 4'(RDEP - 1)) ? 4'h0 :
                            wptr_r[step_idx_r] + 4'h1;
      last_fault_r[step_idx_r] <= flt_l_r;
    end
  end

  always_ff @(posedge clock) begin
    if (step_v_r && on_v != '0) begin
      rec_mem[6'(step_idx_r * RDEP) + 6'(wptr_r[step_idx_r])] <= '{
        ts_l_r,
        on_v[1] ? EV_TRIP : (on_v[0] ? EV_START : EV_BLOCK),
        flt_l_r, hist_r[TRIG_IX], mag_l_r, hist_r[HIST_LEN-1],
        (st_n == ST_START) ? tmr_n : '0, grp_l_r};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      angle_r <= '0;
    end else begin
      angle_r <= 17'(resid_angle) -
                 17'(volt_avail ? vpos_angle : ipos_angle);
    end
  end

  // ================================================================
  // Avalon-MM slave, one wait state per access
  logic [7:0] wa;
  logic [1:0] sa;
  logic [31:0] rd_n;
  eos_rec_t rec_q;
  logic wr_ok;

  assign wa = {avs_address[7:2], 2'b00};
  assign sa = wa[6:5];
  assign wr_ok = avs_write && !avs_waitrequest;

  always_comb begin
    rec_q = rec_mem[6'(rsel_r[`EOS_RSEL_STAGE] * RDEP) +
                    6'(rsel_r[`EOS_RSEL_SLOT])];
    rd_n = 32'h0;
    if (wa[`EOS_STG_BIT]) begin
      if (32'(sa) < NSTAGE) begin
        unique case (wa[4:2])
          `EOS_SR_LEVEL: rd_n = 32'(lvl_r[sa]);
          `EOS_SR_DELAY: rd_n = 32'(dly_r[sa]);
          `EOS_SR_CFG: rd_n = {26'h0, evoff_r[sa], evon_r[sa], fsel_r[sa],
                               inrush_r[sa], inverse_min_time_delay_r[sa]};
          `EOS_SR_STAT: rd_n = {7'h0, ratio_r[sa], 6'h0, st_r[sa]};
          `EOS_SR_REMAIN: rd_n = 32'(remain_r[sa]);
          `EOS_SR_CNT_ST: rd_n = {cnt_tr_r[sa], cnt_st_r[sa]};
          `EOS_SR_CNT_BK: rd_n = 32'(cnt_bk_r[sa]);
          `EOS_SR_FAULT: rd_n = {24'h0, wptr_r[sa], last_fault_r[sa]};
        endcase
      end
    end else begin
      case (wa)
        `EOS_OFF_CTRL: rd_n = {27'h0, force_en_r, kind_r, src_r};
        `EOS_OFF_HARM: rd_n = 32'(harm_lim_r);
        `EOS_OFF_RSEL: rd_n = 32'(rsel_r);
        `EOS_OFF_RTIME: rd_n = rec_q.stamp;
        `EOS_OFF_RA: rd_n = {3'h0, rec_q.group, rec_q.evt, rec_q.fault,
                             rec_q.pre_trig};
        `EOS_OFF_RB: rd_n = 32'(rec_q.cur);
        `EOS_OFF_RC: rd_n = 32'(rec_q.pre_fault);
        `EOS_OFF_RD: rd_n = 32'(rec_q.remain);
        `EOS_OFF_ANGLE: rd_n = 32'(signed'(angle_r));
        default: rd_n = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_n : 32'h0;
    end
  end

  // Settings writable at any time, read live by the sweep
  always_ff @(posedge clock) begin
    if (!nrst) begin
      src_r <= SRC_COARSE;
      kind_r <= KIND_RMS;
      force_en_r <= 1'b0;
      harm_lim_r <= `EOS_HARM_RST;
      rsel_r <= 6'h0;
      cnt_clr_r <= '0;
      inverse_min_time_delay_r <= '0;
      inrush_r <= '0;
      evon_r <= '1;
      evoff_r <= '1;
      for (int i = 0; i < NSTAGE; i++) begin
        lvl_r[i] <= `EOS_LVL_RST;
        dly_r[i] <= `EOS_DLY_RST;
        fsel_r[i] <= ST_NORMAL;
      end
    end else begin
      cnt_clr_r <= '0;
      if (wr_ok && wa[`EOS_STG_BIT] && 32'(sa) < NSTAGE) begin
        unique case (wa[4:2])
          `EOS_SR_LEVEL: lvl_r[sa] <= avs_writedata[`EOS_MAGW-1:0];
          `EOS_SR_DELAY: dly_r[sa] <= avs_writedata[`EOS_TMRW-1:0];
          `EOS_SR_CFG: begin
            inverse_min_time_delay_r[sa] <= avs_writedata[`EOS_CFG_INVERSE_MIN_TIME_DELAY];
            inrush_r[sa] <= avs_writedata[`EOS_CFG_INRUSH];
            fsel_r[sa] <= avs_writedata[`EOS_CFG_FSTATE];
            evon_r[sa] <= avs_writedata[`EOS_CFG_EVON];
            evoff_r[sa] <= avs_writedata[`EOS_CFG_EVOFF];
          end
          default: ;
        endcase
      end else if (wr_ok && !wa[`EOS_STG_BIT]) begin
        case (wa)
          `EOS_OFF_CTRL: begin
            src_r <= avs_writedata[`EOS_CTRL_SRC];
            kind_r <= avs_writedata[`EOS_CTRL_KIND];
            force_en_r <= avs_writedata[`EOS_CTRL_FORCE];
          end
          `EOS_OFF_HARM: harm_lim_r <= avs_writedata[12:0];
          `EOS_OFF_CLR: cnt_clr_r <= avs_writedata[NSTAGE-1:0];
          `EOS_OFF_RSEL: rsel_r <= avs_writedata[5:0];
          default: ;
        endcase
      end
    end
  end

  // ================================================================
  // Checks
  sequence s_sweep_start;
    tick_r ##1 (step_v_r && step_idx_r == 2'h0);
  endsequence
  property p_latch;
    @(posedge clock) disable iff (!nrst)
    s_sweep_start |-> mag_l_r == $past(mag_sel);
  endproperty
  a_latch: assert property (p_latch)
    else $error("magnitude not latched at tick");
  property p_pickup;
    @(posedge clock) disable iff (!nrst)
    step_v_r && !pick_r[step_idx_r] && above |=> pick_r[$past(step_idx_r)];
  endproperty
  a_pickup: assert property (p_pickup)
    else $error("pick-up missed");
  property p_hyst;
    @(posedge clock) disable iff (!nrst)
    step_v_r && pick_r[step_idx_r] && !below |=> pick_r[$past(step_idx_r)];
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("released above hysteresis");
  property p_start;
    @(posedge clock) disable iff (!nrst)
    step_v_r && st_c == ST_NORMAL && pk_n && !blk
      |=> st_r[$past(step_idx_r)] == ST_START;
  endproperty
  a_start: assert property (p_start)
    else $error("start not entered");
  property p_blocked;
    @(posedge clock) disable iff (!nrst)
    step_v_r && st_c == ST_NORMAL && pk_n && blk
      |=> st_r[$past(step_idx_r)] == ST_BLOCKED && remain_r[$past(step_idx_r)] == '0;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("blocked not entered");
  property p_late_block;
    @(posedge clock) disable iff (!nrst)
    step_v_r && st_c == ST_START && pk_n && blk
      |=> tmr_r[$past(step_idx_r)] == $past(dly_r[step_idx_r]);
  endproperty
  a_late_block: assert property (p_late_block)
    else $error("timer not reloaded on block");
  property p_event;
    @(posedge clock) disable iff (!nrst)
    step_v_r && evon_r[step_idx_r] && on_v != '0
      |=> evt_valid && evt_time == $past(ts_l_r) && evt_on == $past(on_v);
  endproperty
  a_event: assert property (p_event)
    else $error("on event lost");
  property p_count;
    @(posedge clock) disable iff (!nrst)
    step_v_r && on_v[0] && !cnt_clr_r[step_idx_r]
      |=> cnt_st_r[$past(step_idx_r)] == $past(cnt_st_r[step_idx_r]) + 16'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("start count not advanced");
  property p_bus;
    @(posedge clock) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer late");
endmodule : eos_stage

// ### verification/eos_front.sv
// Model of the residual measurement front end and blocking matrix.
// Assumes the bench sets the magnitude and block request after edges.
`timescale 1ns/10ps
module eos_front (
  input wire logic clock,
  input wire logic [19:0] mag,
  input wire logic blk,
  output eos_pkg::eos_mag_t m_out,
  output eos_pkg::eos_mag_t harm2,
  output logic [3:0] block,
  output logic [15:0] angle
);
  import eos_pkg::*;
  // ==========================================================
  // Same magnitude on every source, no harmonic content
  always_ff @(posedge clock) begin
    m_out <= mag;
    harm2 <= 20'h00000;
    angle <= 16'h1194;
  end
  // Block raised whole ticks ahead of any delay end
  always_ff @(posedge clock) begin
    block <= {3'h0, blk};
  end
endmodule : eos_front

// ### verification/eos_stage_tb.sv
// Self-checking bench for the residual overcurrent stage.
// Assumes eos_front as magnitude source, short tick of 20 cycles.
`timescale 1ns/10ps
module eos_stage_tb;
  import eos_pkg::*;
  logic clock, nrst, rd, wr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q, stamp;
  logic wait_req, ev_v, va;
  logic [1:0] ev_s;
  logic [2:0] ev_on, ev_off;
  logic [7:0] ev_w;
  logic [31:0] ev_t, ev_dt;
  logic [15:0] ia;
  int ev_n;
  logic [3:0] st, tr, bk;
  logic [19:0] mag;
  logic blk;
  eos_mag_t m, h2;
  logic [3:0] block;
  logic [15:0] ang;
  int fail_count, total_checks;
  eos_front u_eos_front (.clock(clock), .mag(mag), .blk(blk),
    .m_out(m), .harm2(h2), .block(block), .angle(ang));
  eos_stage #(.NSTAGE(4), .TICK_CYC(20)) u_eos_stage (.clock(clock),
    .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .coarse_rms(m), .coarse_trms(m),
    .coarse_pp(m), .sens_rms(m), .sens_trms(m), .sens_pp(m),
    .calc_rms(m), .harm2_mag(h2), .fund_mag(m), .ext_block(block),
    .resid_angle(ang), .vpos_angle(ang), .ipos_angle(ia),
    .volt_avail(va), .fault_phase(2'h1), .fault_fwd(1'b1),
    .setting_group(3'h2), .timestamp(stamp), .stage_start(st),
    .stage_trip(tr), .stage_blocked(bk), .evt_valid(ev_v),
    .evt_stage(ev_s), .evt_on(ev_on), .evt_off(ev_off), .evt_time(ev_t));
  // ==========================================================
  // Clock, time stamp
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stamp <= 32'h0;
    end else begin
      stamp <= stamp + 32'h00000001;
    end
  end
  // Event monitor: count, last word, stamp age
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ev_n <= 0;
    end else if (ev_v) begin
      ev_n <= ev_n + 1;
      ev_w <= {ev_s, ev_on, ev_off};
      ev_dt <= stamp - ev_t;
    end
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // ==========================================================
  // Avalon access, held until waitrequest sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
  endtask : bus
  task automatic ticks(input int n);
    repeat (n * 20) @(posedge clock);
  endtask : ticks
  task automatic outs(input logic [2:0] e);
    chk("start/trip/blocked", {29'h0, e}, {29'h0, bk[0], tr[0], st[0]});
  endtask : outs
  // ==========================================================
  // Scenarios
  task automatic regs_reset;
    bus(1'b0, 8'h80, 32'h0);
    chk("level", 32'h00002EE0, q);
    bus(1'b0, 8'h88, 32'h0);
    chk("cfg", 32'h00000030, q);
    bus(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 8'h80, 32'h000003E8);
    bus(1'b1, 8'h84, 32'h00000003);
  endtask : regs_reset
  task automatic pickup_trip;
    mag <= 20'h003E9;
    ticks(2);
    outs(3'b001);
    chk("other stage", 32'h0, {31'h0, st[1]});
    bus(1'b0, 8'h8C, 32'h0);
    chk("status", 32'h00006401, q);
    bus(1'b0, 8'h90, 32'h0);
    chk("remain", 32'h00000002, q);
    ticks(5);
    outs(3'b011);
    mag <= 20'h003D4;
    ticks(2);
    chk("hysteresis", 32'h1, {31'h0, st[0]});
    mag <= 20'h003C0;
    ticks(2);
    outs(3'b000);
  endtask : pickup_trip
  task automatic blocked_first;
    blk <= 1'b1;
    ticks(1);
    mag <= 20'h003E9;
    ticks(2);
    outs(3'b100);
    ticks(5);
    chk("no trip", 32'h0, {31'h0, tr[0]});
    mag <= 20'h003C0;
    blk <= 1'b0;
    ticks(2);
  endtask : blocked_first
  task automatic block_late;
    mag <= 20'h003E9;
    ticks(2);
    outs(3'b001);
    blk <= 1'b1;
    ticks(2);
    chk("start dropped", 32'h0, {31'h0, st[0]});
    ticks(5);
    chk("no trip", 32'h0, {31'h0, tr[0]});
    mag <= 20'h003C0;
    blk <= 1'b0;
    ticks(2);
    chk("event count", 32'h00000008, ev_n);
    chk("last event", 32'h00000004, {24'h0, ev_w});
    chk("event stamp", 32'h00000002, ev_dt);
  endtask : block_late
  task automatic counts;
    bus(1'b0, 8'h94, 32'h0);
    chk("trip start cnt", 32'h00010002, q);
    bus(1'b0, 8'h98, 32'h0);
    chk("block cnt", 32'h00000002, q);
    bus(1'b1, 8'h08, 32'h00000001);
    bus(1'b0, 8'h94, 32'h0);
    chk("cleared", 32'h0, q);
    bus(1'b1, 8'h0C, 32'h00000003);
    bus(1'b0, 8'h14, 32'h0);
    chk("record a", 32'h087003E9, q);
    bus(1'b0, 8'h20, 32'h0);
    chk("record remain", 32'h00000003, q);
  endtask : counts
  task automatic angle_ref;
    bus(1'b0, 8'h24, 32'h0);
    chk("angle v", 32'h0, q);
    va <= 1'b0;
    ia <= 16'h0FA0;
    bus(1'b0, 8'h24, 32'h0);
    chk("angle i", 32'h000001F4, q);
  endtask : angle_ref
  task automatic forcing;
    bus(1'b1, 8'hA8, 32'h00000038);
    bus(1'b1, 8'h00, 32'h00000010);
    ticks(1);
    chk("forced trip", 32'h1, {31'h0, tr[1]});
    bus(1'b1, 8'h00, 32'h0);
    ticks(1);
    chk("force off", 32'h0, {31'h0, tr[1]});
  endtask : forcing
  initial begin
    fail_count = 0;
    total_checks = 0;
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    mag = 20'h00000;
    blk = 1'b0;
    va = 1'b1;
    ia = 16'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    regs_reset();
    pickup_trip();
    blocked_first();
    block_late();
    counts();
    angle_ref();
    forcing();
    complete_run();
  end
endmodule : eos_stage_tb
